// >>> rtl/ptm_pkg.sv
// periodic timer package: offsets, fields, codes, bus and state types
// assumes a single 125 MHz core clock and an AHB-Lite master
package ptm_pkg;
  // counter width and top value
  localparam int          CNT_W   = 10;
  localparam logic [9:0]  CNT_MAX = 10'h3ff;
  // byte offsets of the word-aligned registers
  localparam logic [7:0] OFF_CTRL_A  = 8'h00;
  localparam logic [7:0] OFF_CTRL_B  = 8'h04;
  localparam logic [7:0] OFF_CNT_LO  = 8'h08;
  localparam logic [7:0] OFF_CNT_HI  = 8'h0c;
  localparam logic [7:0] OFF_CMPA_LO = 8'h10;
  localparam logic [7:0] OFF_CMPA_HI = 8'h14;
  localparam logic [7:0] OFF_CMPP_LO = 8'h18;
  localparam logic [7:0] OFF_CMPP_HI = 8'h1c;
  // timer_ctrl_a fields
  localparam int BIT_HOLD   = 7;
  localparam int CLKSEL_LSB = 4;
  localparam int BIT_ON     = 3;
  localparam logic [7:0] CTRL_A_MASK = 8'hf8;
  // timer_ctrl_b fields
  localparam int MODE_LSB   = 6;
  localparam int PINF_LSB   = 4;
  localparam int BIT_OC     = 3;
  localparam int BIT_INV    = 2;
  localparam int BIT_CAPSRC = 1;
  localparam int BIT_CLRSRC = 0;
  // reset values
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [9:0] CMP_RST    = 10'h000;
  // pin function codes
  localparam logic [1:0] PF_0 = 2'h0;
  localparam logic [1:0] PF_1 = 2'h1;
  localparam logic [1:0] PF_2 = 2'h2;
  localparam logic [1:0] PF_3 = 2'h3;
  // count clock sources
  typedef enum logic [2:0] {
    CK_SYS_DIV4 = 3'h0, CK_SYS = 3'h1, CK_FAST16 = 3'h2,
    CK_FAST64 = 3'h3, CK_SLOW_A = 3'h4, CK_SLOW_B = 3'h5,
    CK_EXT_RISE = 3'h6, CK_EXT_FALL = 3'h7
  } ptm_clk_sel_t;
  // operating modes
  typedef enum logic [1:0] {
    MODE_CMP = 2'h0, MODE_CAP = 2'h1, MODE_PWM = 2'h2, MODE_TMR = 2'h3
  } ptm_mode_t;
  // timing: fast clock is the core clock here
  localparam int CORE_CLK_HZ = 125_000_000;
  localparam int SLOW_CLK_HZ = 32_000;
  localparam int DIV_SYS4    = 4;
  localparam int DIV_FAST16  = 16;
  localparam int DIV_FAST64  = 64;
  localparam int DIV_SLOW    = CORE_CLK_HZ / SLOW_CLK_HZ;
  // ahb-lite request and response carriers
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } ptm_ahb_req_t;
  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } ptm_ahb_rsp_t;
  // whole state of the timer core
  typedef struct packed {
    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
    logic [9:0]  count;
    logic [9:0]  cmp_a;
    logic [9:0]  cmp_p;
    logic        out_lvl;
    logic        pin_q;
    logic        pin_oe;
    logic        dp_wr;
    logic [7:0]  dp_addr;
    logic [31:0] rdata;
    logic        evt_a;
    logic        evt_p;
    logic        evt_ovf;
    logic        evt_cap;
  } ptm_state_t;
endpackage : ptm_pkg

// >>> rtl/ptm_tick_div.sv
// divider giving a one-cycle enable every DIV core clocks
// assumes DIV is at least 2 and the core clock runs free
`timescale 1ns/10ps
module ptm_tick_div
  import ptm_pkg::*;
#(
  parameter int DIV = 4 // core clocks per enable pulse
) (
  input  wire logic core_clk, // core clock
  input  wire logic rst_n,    // synchronous reset, active low
  output logic      tick      // one-cycle enable pulse
);
  localparam int CW = $clog2(DIV);
  // local state: counter and registered pulse
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } ptm_div_state_t;
  ptm_div_state_t s_reg;  // present state
  ptm_div_state_t s_next; // next state

  // wrap the counter and flag the wrap
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.cnt == CW'(DIV - 1)) begin
      s_next.cnt  = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + CW'(1);
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;
endmodule : ptm_tick_div

// >>> rtl/ptm_pin_edge.sv
// two-flop synchroniser with edge detect for an asynchronous pin
// assumes the pin is slower than half the core clock
`timescale 1ns/10ps
module ptm_pin_edge
  import ptm_pkg::*;
(
  input  wire logic core_clk, // core clock
  input  wire logic rst_n,    // synchronous reset, active low
  input  wire logic pin,      // raw pin level
  output logic      rise,     // one-cycle pulse on rising edge
  output logic      fall      // one-cycle pulse on falling edge
);
  // first stage is read only by the second
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } ptm_sync_state_t;
  ptm_sync_state_t s_reg;  // present state
  ptm_sync_state_t s_next; // next state

  // shift the pin through three stages
  always_comb begin
    s_next    = s_reg;
    s_next.s1 = pin;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // edges seen between the settled stages only
  assign rise = s_reg.s2 & ~s_reg.s3;
  assign fall = ~s_reg.s2 & s_reg.s3;
endmodule : ptm_pin_edge

// >>> rtl/ptm_core.sv
// periodic timer core: ahb-lite registers, 10-bit counter, compare,
// capture, pwm and single pulse output
// assumes one 125 MHz core clock; pins are asynchronous to it
//
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps

// Functional notes
// RULE_01: hold bit freezes counter, resumes from value
// RULE_02: three-bit selector picks count clock source
// RULE_03: module-on rising edge clears the counter
// RULE_04: module off stops counting, value retained
// RULE_05: on rising edge, pin returns to initial
// RULE_06: control A low three bits read zero
// RULE_07: two-bit selector picks operating mode
// RULE_08: software turns module off before mode change
// RULE_09: timer mode leaves the pin undriven
// RULE_10: compare A match: keep, low, high, toggle
// RULE_11: pwm codes: inactive, active, pwm, pulse
// RULE_12: capture edge: rise, fall, both, disabled
// RULE_13: software picks match level unlike initial
// RULE_14: pwm pin codes changed only while off
// RULE_15: counter readable, comparators read/write pairs
// RULE_16: overflow or match clears counter, flags event
// RULE_17: clear source: 0 comparator P, 1 A
// RULE_18: output level bit: polarity or initial level
// RULE_19: invert bit flips pin, not in timer
// RULE_20: unused high-byte bits read zero
// RULE_21: external count pin synchronised before use
module ptm_core
  import ptm_pkg::*;
#(
  parameter int SLOW_DIV = DIV_SLOW // core clocks per slow tick
) (
  input  wire logic   core_clk,         // core clock
  input  wire logic   rst_n,            // sync reset, active low
  input  ptm_ahb_req_t ahb_in,          // ahb-lite request
  output ptm_ahb_rsp_t ahb_out,         // ahb-lite response
  input  wire logic   ext_clk_pin,      // external count clock pin
  input  wire logic   capture_in_pin,   // capture input pin
  output logic        waveform_out_pin, // waveform output level
  output logic        waveform_out_oe,  // waveform output enable
  output logic        match_a_evt,      // comparator A event
  output logic        match_p_evt,      // comparator P event
  output logic        overflow_evt,     // counter overflow event
  output logic        capture_evt       // capture event
);
  ptm_state_t s_reg;  // present state
  ptm_state_t s_next; // next state

  // enable pulses from the dividers
  logic tick_div4;  // system clock / 4
  logic tick_f16;   // fast clock / 16
  logic tick_f64;   // fast clock / 64
  logic tick_slow;  // slow clock rate
  // synchronised pin edges
  logic ext_rise;   // external clock pin rising
  logic ext_fall;   // external clock pin falling
  logic cap_rise;   // capture pin rising
  logic cap_fall;   // capture pin falling

  // decoded fields, shared with the checks below
  ptm_mode_t    mode;     // present operating mode
  ptm_clk_sel_t clk_sel;  // present count clock source
  logic [1:0]   pinf;     // pin function code
  logic         oc;       // output level control
  logic         on_q;     // module on
  logic         hold_q;   // count hold
  logic         on_rise;  // module-on going high this cycle
  logic         tick;     // selected count clock enable
  logic         run;      // counter advances this cycle
  logic [9:0]   cnt_inc;  // counter plus one
  logic         hit_a;    // comparator A match on this step
  logic         hit_p;    // comparator P match on this step
  logic         cnt_clr;  // counter clears on this step
  logic         cap_edge; // selected capture edge seen
  logic         acc;      // address phase accepted
  logic         mapped;   // address hits the register map

  // internal rates; the fast clock equals the core clock here
  ptm_tick_div #(.DIV(DIV_SYS4)) u_div4 (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick     (tick_div4)
  );
  ptm_tick_div #(.DIV(DIV_FAST16)) u_div16 (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick     (tick_f16)
  );
  ptm_tick_div #(.DIV(DIV_FAST64)) u_div64 (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick     (tick_f64)
  );
  ptm_tick_div #(.DIV(SLOW_DIV)) u_divslow (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick     (tick_slow)
  );

  // both pins pass two flops before any edge logic
  ptm_pin_edge u_ext_edge ( // RULE_21
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin      (ext_clk_pin),
    .rise     (ext_rise),
    .fall     (ext_fall)
  );
  ptm_pin_edge u_cap_edge (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin      (capture_in_pin),
    .rise     (cap_rise),
    .fall     (cap_fall)
  );

  // register read mux; unused upper bits come back as zero
  function automatic logic [7:0] read_reg(input ptm_state_t st,
                                          input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    unique case (a)
      OFF_CTRL_A:  d = st.ctrl_a;
      OFF_CTRL_B:  d = st.ctrl_b;
      OFF_CNT_LO:  d = st.count[7:0];             // RULE_15
      OFF_CNT_HI:  d = {6'h00, st.count[9:8]};    // RULE_20
      OFF_CMPA_LO: d = st.cmp_a[7:0];
      OFF_CMPA_HI: d = {6'h00, st.cmp_a[9:8]};    // RULE_20
      OFF_CMPP_LO: d = st.cmp_p[7:0];
      OFF_CMPP_HI: d = {6'h00, st.cmp_p[9:8]};    // RULE_20
      default:     d = 8'h00;
    endcase
    return d;
  endfunction : read_reg

  // field decode from the present control registers
  always_comb begin
    mode    = ptm_mode_t'(s_reg.ctrl_b[MODE_LSB +: 2]);   // RULE_07
    clk_sel = ptm_clk_sel_t'(s_reg.ctrl_a[CLKSEL_LSB +: 3]);
    pinf    = s_reg.ctrl_b[PINF_LSB +: 2];
    oc      = s_reg.ctrl_b[BIT_OC];
    on_q    = s_reg.ctrl_a[BIT_ON];
    hold_q  = s_reg.ctrl_a[BIT_HOLD];
  end

  // count clock selection, one enable per source
  always_comb begin
    unique case (clk_sel)                                 // RULE_02
      CK_SYS_DIV4: tick = tick_div4;
      CK_SYS:      tick = 1'b1;
      CK_FAST16:   tick = tick_f16;
      CK_FAST64:   tick = tick_f64;
      CK_SLOW_A:   tick = tick_slow;
      CK_SLOW_B:   tick = tick_slow;
      CK_EXT_RISE: tick = ext_rise;
      CK_EXT_FALL: tick = ext_fall;
    endcase
  end

  // capture edge selection; both pins already synchronised
  always_comb begin
    logic r;
    logic f;
    r = s_reg.ctrl_b[BIT_CAPSRC] ? ext_rise : cap_rise;
    f = s_reg.ctrl_b[BIT_CAPSRC] ? ext_fall : cap_fall;
    unique case (pinf)                                    // RULE_12
      PF_0: cap_edge = r;
      PF_1: cap_edge = f;
      PF_2: cap_edge = r | f;
      PF_3: cap_edge = 1'b0;
    endcase
  end

  // counter step and comparator matches
  always_comb begin
    run     = on_q & ~hold_q & tick;                      // RULE_01 RULE_04
    cnt_inc = s_reg.count + 10'h001;
    // a match clears on the step that would reach the value,
    // so a zero compare value means a full 1024-count period
    hit_a   = run & (cnt_inc == s_reg.cmp_a);
    hit_p   = run & (cnt_inc == s_reg.cmp_p);
    // pwm period always comes from comparator P
    if (mode == MODE_PWM) begin
      cnt_clr = hit_p;
    end else if (s_reg.ctrl_b[BIT_CLRSRC]) begin          // RULE_17
      cnt_clr = hit_a;
    end else begin
      cnt_clr = hit_p;
    end
  end

  // ahb-lite address phase decode
  always_comb begin
    acc    = ahb_in.hsel & ahb_in.htrans[1] & ahb_in.hready;
    mapped = (ahb_in.haddr[31:8] == 24'h000000) &&
             (ahb_in.haddr[1:0] == 2'h0) &&
             (ahb_in.haddr[7:0] <= OFF_CMPP_HI);
  end

  // next state: bus write, counter, capture, output, read data
  always_comb begin
    s_next         = s_reg;
    s_next.evt_a   = 1'b0;
    s_next.evt_p   = 1'b0;
    s_next.evt_ovf = 1'b0;
    s_next.evt_cap = 1'b0;
    // data phase write; unmapped addresses never get here
    if (s_reg.dp_wr) begin
      unique case (s_reg.dp_addr)
        OFF_CTRL_A:
          s_next.ctrl_a = ahb_in.hwdata[7:0] & CTRL_A_MASK; // RULE_06
        OFF_CTRL_B:  s_next.ctrl_b = ahb_in.hwdata[7:0];
        OFF_CMPA_LO: s_next.cmp_a[7:0] = ahb_in.hwdata[7:0];
        OFF_CMPA_HI: s_next.cmp_a[9:8] = ahb_in.hwdata[1:0]; // RULE_20
        OFF_CMPP_LO: s_next.cmp_p[7:0] = ahb_in.hwdata[7:0];
        OFF_CMPP_HI: s_next.cmp_p[9:8] = ahb_in.hwdata[1:0]; // RULE_20
        default: ;  // counter pair is read only
      endcase
    end
    // counting; overflow wraps to zero on its own
    if (run) begin
      s_next.count   = cnt_clr ? 10'h000 : cnt_inc;       // RULE_16
      s_next.evt_ovf = (s_reg.count == CNT_MAX);
      s_next.evt_a   = hit_a;
      // with comparator A clearing, P raises no event
      s_next.evt_p   = hit_p & ~(s_reg.ctrl_b[BIT_CLRSRC] &
                                 (mode != MODE_PWM));
    end
    // capture stores the count in the comparator A pair
    if (mode == MODE_CAP && on_q && cap_edge) begin
      s_next.cmp_a   = s_reg.count;                       // RULE_12
      s_next.evt_cap = 1'b1;
    end
    // pin level, only while the module is on
    if (on_q && mode == MODE_CMP && hit_a) begin
      unique case (pinf)                                  // RULE_10
        PF_0: s_next.out_lvl = s_reg.out_lvl;
        PF_1: s_next.out_lvl = 1'b0;
        PF_2: s_next.out_lvl = 1'b1;
        PF_3: s_next.out_lvl = ~s_reg.out_lvl;
      endcase
    end else if (on_q && mode == MODE_PWM) begin
      unique case (pinf)                                  // RULE_11
        PF_0: s_next.out_lvl = ~oc;
        PF_1: s_next.out_lvl = oc;
        // duty from comparator A, polarity from oc
        PF_2: s_next.out_lvl = (s_next.count < s_reg.cmp_a) ?
                               oc : ~oc;                  // RULE_18
        PF_3: s_next.out_lvl = hit_a ? ~oc : s_reg.out_lvl;
      endcase
    end
    // module switched on: clear count, restore initial pin level
    on_rise = s_next.ctrl_a[BIT_ON] & ~on_q;
    if (on_rise) begin
      s_next.count = 10'h000;                             // RULE_03
      if (mode == MODE_CMP || mode == MODE_PWM) begin
        s_next.out_lvl = oc;                              // RULE_05 RULE_18
      end
    end
    // pin from flops; invert and enable follow the new settings
    s_next.pin_q  = s_next.out_lvl ^ s_next.ctrl_b[BIT_INV]; // RULE_19
    s_next.pin_oe = (s_next.ctrl_b[MODE_LSB +: 2] == MODE_CMP) ||
                    (s_next.ctrl_b[MODE_LSB +: 2] == MODE_PWM); // RULE_09
    // address phase; read data taken after this cycle's update
    s_next.dp_wr   = acc & ahb_in.hwrite & mapped;
    s_next.dp_addr = ahb_in.haddr[7:0];
    s_next.rdata   = 32'h00000000;
    if (acc && !ahb_in.hwrite && mapped) begin
      s_next.rdata = {24'h000000, read_reg(s_next, ahb_in.haddr[7:0])};
    end
  end

  // single state register, synchronous reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_reg        <= '0;
      s_reg.ctrl_a <= CTRL_A_RST;
      s_reg.ctrl_b <= CTRL_B_RST;
      s_reg.cmp_a  <= CMP_RST;
      s_reg.cmp_p  <= CMP_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // zero wait states, always OKAY
  assign ahb_out.hrdata    = s_reg.rdata;
  assign ahb_out.hreadyout = 1'b1;
  assign ahb_out.hresp     = 1'b0;
  // pin and event outputs straight from flops
  assign waveform_out_pin  = s_reg.pin_q;
  assign waveform_out_oe   = s_reg.pin_oe;
  assign match_a_evt       = s_reg.evt_a;
  assign match_p_evt       = s_reg.evt_p;
  assign overflow_evt      = s_reg.evt_ovf;
  assign capture_evt       = s_reg.evt_cap;

  // checks, all in the core clock domain
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // hold freezes the count while the module stays on
  AST_HOLD_FREEZE: assert property ( // RULE_01
    on_q && hold_q && !on_rise |=> $stable(s_reg.count))
    else $error("counter moved while held");

  // an external edge advances or clears the counter next cycle
  AST_EXT_STEP: assert property ( // RULE_21
    on_q && !hold_q && clk_sel == CK_EXT_RISE && ext_rise && !on_rise
    |=> s_reg.count == $past(cnt_inc) || s_reg.count == 10'h000)
    else $error("external edge did not step counter");

  // switching on clears the count
  AST_ON_CLEAR: assert property ( // RULE_03
    on_rise |=> s_reg.count == 10'h000)
    else $error("count not cleared on switch-on");
  // while off the count stays put
  AST_OFF_FROZEN: assert property ( // RULE_04
    !on_q && !on_rise |=> $stable(s_reg.count))
    else $error("count moved while off");

  // compare mode switch-on restores the initial level
  AST_ON_INIT_PIN: assert property ( // RULE_05
    on_rise && mode == MODE_CMP |=> s_reg.out_lvl == $past(oc))
    else $error("pin not restored on switch-on");
  // reserved control bits always zero
  AST_RESV_ZERO: assert property ( // RULE_06
    s_reg.ctrl_a[2:0] == 3'h0)
    else $error("reserved control bits set");

  // compare toggle flips the pin on an A match
  AST_CMP_TOGGLE: assert property ( // RULE_10
    on_q && mode == MODE_CMP && pinf == PF_3 && hit_a && !on_rise
    |=> s_reg.out_lvl != $past(s_reg.out_lvl))
    else $error("toggle on match missing");

  // compare drive-high sets the pin, event pulse the same cycle
  AST_CMP_HIGH: assert property ( // RULE_10
    on_q && mode == MODE_CMP && pinf == PF_2 && hit_a && !on_rise
    |=> s_reg.out_lvl && match_a_evt)
    else $error("drive-high on match missing");

  // pwm forced inactive level follows the polarity bit
  AST_PWM_FORCE: assert property ( // RULE_11
    on_q && mode == MODE_PWM && pinf == PF_0 && $stable(s_reg.ctrl_b)
    |=> s_reg.out_lvl == !$past(oc))
    else $error("pwm inactive level wrong");
  // disabled capture never fires
  AST_CAP_OFF: assert property ( // RULE_12
    mode == MODE_CAP && pinf == PF_3 |=> !capture_evt)
    else $error("capture fired while disabled");

  // A selected as clear source wipes the count on its match
  AST_CLR_A: assert property ( // RULE_17
    mode == MODE_CMP && s_reg.ctrl_b[BIT_CLRSRC] && hit_a && !on_rise
    |=> s_reg.count == 10'h000 && !match_p_evt)
    else $error("comparator A did not clear counter");
  // no drive in timer mode; pin is level xor invert otherwise
  AST_PIN_OE: assert property ( // RULE_09
    mode == MODE_TMR |-> !waveform_out_oe)
    else $error("pin driven in timer mode");
  AST_PIN_INV: assert property ( // RULE_19
    waveform_out_pin == (s_reg.out_lvl ^ s_reg.ctrl_b[BIT_INV]))
    else $error("pin polarity wrong");
  // main scenarios
  COV_ON_RISE: cover property (on_rise);
  COV_CAPTURE: cover property (capture_evt);
  COV_PWM_PERIOD: cover property (mode == MODE_PWM && hit_p);
  COV_OVERFLOW: cover property (overflow_evt);
endmodule : ptm_core

// >>> sim/testbench.sv
// self-checking bench for the periodic timer core over ahb-lite
// assumes ptm_core answers with no wait states; pins held quiet at reset
`timescale 1ns/10ps
module testbench import ptm_pkg::*;;
  logic         core_clk;       // 125 MHz core clock
  logic         rst_n;          // sync reset, active low
  logic         hsel;           // ahb select
  logic         hwrite;         // ahb direction
  logic [31:0]  haddr;          // ahb byte address
  logic [31:0]  hwdata;         // ahb write data
  logic [1:0]   htrans;         // ahb transfer kind
  logic [2:0]   hsize;          // ahb size, always word
  logic         ext_pin;        // external count clock stimulus
  logic         cap_pin;        // capture input stimulus
  ptm_ahb_rsp_t rsp;            // ahb response
  logic         pin;            // waveform output level
  logic         oe;             // waveform output enable
  logic         cap_evt;        // capture event pulse
  logic         ma_evt;         // comparator A event pulse
  logic         mp_evt;         // comparator P event pulse
  logic         ov_evt;         // overflow event pulse
  int           n_ma = 0;       // comparator A events seen
  int           n_mp = 0;       // comparator P events seen
  int           n_ov = 0;       // overflow events seen
  int           n_fail = 0;     // mismatches
  int           n_compared = 0; // comparisons made
  int           n_cap = 0;      // capture events seen
  int           n0;             // event count at scenario start
  logic [31:0]  rd;             // last read data
  logic [31:0]  rd2;            // earlier read data
  logic [7:0]   cb [9];         // pin scenarios: control b value
  logic [1:0]   ex [9];         // pin scenarios: {initial, after match}
  int           dv [6];         // core clocks per count step by source

  // hready is the single slave's own hreadyout
  ptm_core #(.SLOW_DIV(8)) ptm_core_inst (
    .core_clk(core_clk), .rst_n(rst_n),
    .ahb_in({hsel, haddr, htrans, hwrite, hsize, hwdata, rsp.hreadyout}),
    .ahb_out(rsp), .ext_clk_pin(ext_pin), .capture_in_pin(cap_pin),
    .waveform_out_pin(pin), .waveform_out_oe(oe), .match_a_evt(ma_evt),
    .match_p_evt(mp_evt), .overflow_evt(ov_evt), .capture_evt(cap_evt));

  // clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // tally capture, match and overflow pulses; the bench reads differences only
  always @(posedge core_clk) begin
    if (cap_evt === 1'b1) n_cap <= n_cap + 1;
    if (ma_evt === 1'b1) n_ma <= n_ma + 1;
    if (mp_evt === 1'b1) n_mp <= n_mp + 1;
    if (ov_evt === 1'b1) n_ov <= n_ov + 1;
  end

  // sample hready before the edge so the edge's own update cannot race
  task automatic wait_rdy(output ptm_ahb_rsp_t r);
    do begin
      @(negedge core_clk);
      r = rsp;
      @(posedge core_clk);
    end while (r.hreadyout !== 1'b1);
  endtask : wait_rdy

  // one single word transfer; read data lands in rd
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] wd);
    ptm_ahb_rsp_t r;
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy(r);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    wait_rdy(r);
    rd = r.hrdata;
  endtask : xfer

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    check(rd, exp);
  endtask : rdchk

  // pin must be driven at the expected level
  task automatic pchk(input logic e);
    @(negedge core_clk);
    check({30'h0, oe, pin}, {30'h0, 1'b1, e});
  endtask : pchk

  // both pins pulse together; each scenario listens to only one
  task automatic pulse;
    ext_pin <= 1'b1;
    cap_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    ext_pin <= 1'b0;
    cap_pin <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask : pulse

  task automatic wrap_up;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // watchdog: the whole sequence needs well under 6000 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ext_pin = 1'b0;
    cap_pin = 1'b0;
    // order chosen so each compare-mode initial level differs from the last pin level
    cb = '{8'h19, 8'h09, 8'h21, 8'h31, 8'h88, 8'h98, 8'h9c, 8'ha0, 8'hb8};
    ex = '{2'h2, 2'h3, 2'h1, 2'h1, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0};
    dv = '{4, 1, 16, 64, 8, 8};
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    // reset values, read-only and unused bits, unmapped place
    rdchk(OFF_CTRL_A, 32'h0);
    rdchk(OFF_CTRL_B, 32'h0);
    xfer(OFF_CTRL_A, 1'b1, 32'hf7);
    rdchk(OFF_CTRL_A, 32'hf0);
    xfer(OFF_CMPA_HI, 1'b1, 32'hff);
    rdchk(OFF_CMPA_HI, 32'h3);
    xfer(OFF_CMPA_LO, 1'b1, 32'h10);
    rdchk(OFF_CMPA_LO, 32'h10);
    xfer(OFF_CMPA_HI, 1'b1, 32'h0);
    xfer(OFF_CNT_LO, 1'b1, 32'h55);
    rdchk(OFF_CNT_LO, 32'h0);
    rdchk(8'h20, 32'h0);
    // internal sources: rate, hold, clear on switch-on, keep when off
    xfer(OFF_CTRL_B, 1'b1, 32'hc0);
    for (int s = 0; s < 6; s++) begin
      xfer(OFF_CTRL_A, 1'b1, {24'h0, 1'b0, 3'(s), 4'h8});
      repeat (128) @(posedge core_clk);
      xfer(OFF_CTRL_A, 1'b1, {24'h0, 1'b1, 3'(s), 4'h8});
      xfer(OFF_CNT_LO, 1'b0, 32'h0);
      rd2 = rd;
      repeat (20) @(posedge core_clk);
      rdchk(OFF_CNT_LO, rd2);
      check({31'h0, rd2 >= 128 / dv[s] && rd2 <= 131 / dv[s] + 3}, 1);
      xfer(OFF_CTRL_A, 1'b1, 32'h0);
      rdchk(OFF_CNT_LO, rd2);
    end
    // external pin edges, rising then falling
    for (int s = 6; s < 8; s++) begin
      xfer(OFF_CTRL_A, 1'b1, {24'h0, 1'b0, 3'(s), 4'h8});
      repeat (5) pulse();
      repeat (8) @(posedge core_clk);
      rdchk(OFF_CNT_LO, 32'h5);
      xfer(OFF_CTRL_A, 1'b1, 32'h0);
    end
    // comparator P at 8 clears the count every 8 steps; 43 steps run
    xfer(OFF_CMPP_LO, 1'b1, 32'h8);
    n0 = n_mp;
    xfer(OFF_CTRL_A, 1'b1, 32'h18);
    repeat (40) @(posedge core_clk);
    xfer(OFF_CTRL_A, 1'b1, 32'h0);
    check(n_mp - n0, 5);
    rdchk(OFF_CNT_LO, 32'h3);
    // comparator P at zero lets the count wrap once in 1033 steps
    xfer(OFF_CMPP_LO, 1'b1, 32'h0);
    n0 = n_ov;
    xfer(OFF_CTRL_A, 1'b1, 32'h18);
    repeat (1030) @(posedge core_clk);
    xfer(OFF_CTRL_A, 1'b1, 32'h0);
    check(n_ov - n0, 1);
    // capture edge codes: rise, fall, both, disabled
    for (int p = 0; p < 4; p++) begin
      xfer(OFF_CTRL_B, 1'b1, {26'h1, 2'(p), 2'h0, p[0], 1'b0});
      xfer(OFF_CTRL_A, 1'b1, 32'h18);
      n0 = n_cap;
      pulse();
      repeat (8) @(posedge core_clk);
      check(n_cap - n0, p == 2 ? 2 : (p == 3 ? 0 : 1));
      xfer(OFF_CTRL_A, 1'b1, 32'h0);
    end
    // capture overwrote comparator A; put it back at 16
    xfer(OFF_CMPA_LO, 1'b1, 32'h10);
    xfer(OFF_CMPA_HI, 1'b1, 32'h0);
    // compare and pwm pin behaviour, comparator A at 16
    for (int i = 0; i < 9; i++) begin
      xfer(OFF_CTRL_B, 1'b1, {24'h0, cb[i]});
      n0 = n_ma;
      xfer(OFF_CTRL_A, 1'b1, 32'h18);
      if (cb[i][7:6] == 2'h0) pchk(ex[i][1]);
      repeat (20) @(posedge core_clk);
      pchk(ex[i][0]);
      xfer(OFF_CTRL_A, 1'b1, 32'h0);
      check(n_ma - n0, 1);
    end
    wrap_up();
  end
endmodule : testbench
